// ===== verilog/subtract_swap_skip_pkg.sv
// constants, register map and enumerations for the subtract/swap/skip unit
package subtract_swap_skip_pkg;

  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam int unsigned       AXI_AW       = 4;
  localparam logic [AXI_AW-1:0] ADDR_WREG    = 4'h0;
  localparam logic [AXI_AW-1:0] ADDR_STATUS  = 4'h4;
  localparam logic [AXI_AW-1:0] ADDR_SKIPS   = 4'h8;
  localparam logic [1:0]        RESP_OKAY    = 2'h0;
  localparam logic [1:0]        RESP_SLVERR  = 2'h2;

  // ****************************************
  // status flag layout and reset values
  // ****************************************
  localparam int unsigned FLAG_W         = 4;
  localparam int unsigned FLG_BORROW     = 0;
  localparam int unsigned FLG_NIB_BORROW = 1;
  localparam int unsigned FLG_ZERO       = 2;
  localparam int unsigned FLG_WRAP       = 3;
  localparam logic [FLAG_W-1:0] FLAGS_RST = 4'h0;
  localparam logic [7:0]        WREG_RST  = 8'h00;
  localparam logic [7:0]        BYTE_ZERO = 8'h00;
  localparam int unsigned       NIB       = 4;

  // ****************************************
  // operations and sequencer states
  // ****************************************
  typedef enum logic [2:0] {
    OP_SUB, OP_SUB_MEM, OP_SUBI, OP_SWAP, OP_SWAP_W, OP_SKIP_Z, OP_SKIP_Z_LOAD, OP_SKIP_BIT
  } exec_op_e;

  typedef enum logic {ST_RUN, ST_DUMMY} seq_state_e;

endpackage

// ===== verilog/subtract_swap_skip_exec.sv
// execution unit for subtract, nibble exchange and conditional skip
// Contract
// - memory subtract writes W minus byte back
// - borrow flag 0 if negative, else 1
// - immediate subtract into W, update flags
// - in-place nibble exchange of memory byte
// - nibble exchange into W, memory untouched
// - skip next when memory byte is zero
// - taken skip adds one dummy cycle
// - copy byte to W, skip if zero
// - skip when selected bit is zero
// - no skip means no dummy cycle
//
// The implementer's own choices: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
module subtract_swap_skip_exec
  import subtract_swap_skip_pkg::*;
#(
  parameter int unsigned MEM_AW = 8,
  parameter int unsigned CNT_W  = 16
)(
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // instruction issue from the sequencer
  input  wire logic              exec_valid,
  output logic                   exec_ready,
  input  wire exec_op_e          exec_op,
  input  wire logic [MEM_AW-1:0] exec_addr,
  input  wire logic [7:0]        exec_imm,
  input  wire logic [2:0]        exec_bit,
  input  wire logic [7:0]        mem_rdata,
  // results toward sequencer and data memory
  output logic                   exec_done,
  output logic                   skip_taken,
  output logic                   dummy_slot,
  output logic                   mem_we,
  output logic [MEM_AW-1:0]      mem_waddr,
  output logic [7:0]             mem_wdata,
  output logic [7:0]             working_register,
  // axi4-lite slave
  input  wire logic [AXI_AW-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [AXI_AW-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);

  // ****************************************
  // state and datapath signals
  // ****************************************
  seq_state_e          state_r;
  logic [7:0]          w_r;
  logic [FLAG_W-1:0]   flags_r;
  logic [CNT_W-1:0]    skips_r;
  logic                accept;
  logic                is_sub;
  logic                skip_cond;
  logic [7:0]          operand;
  logic [8:0]          diff;
  logic [NIB:0]        nib_diff;
  logic [7:0]          swapped;
  logic [FLAG_W-1:0]   flags_nxt;
  logic                wr_fire;
  logic                rd_fire;
  logic                wr_wreg;
  logic                wr_status;

  assign accept           = exec_valid && exec_ready;
  assign exec_ready       = (state_r == ST_RUN);
  assign dummy_slot       = (state_r == ST_DUMMY);
  assign working_register = w_r;

  // subtract operand and nine-bit difference, top bit is the borrow out
  always_comb
  begin
    is_sub   = (exec_op == OP_SUB) || (exec_op == OP_SUB_MEM) || (exec_op == OP_SUBI);
    operand  = (exec_op == OP_SUBI) ? exec_imm : mem_rdata;
    diff     = {1'b0, w_r} - {1'b0, operand};
    nib_diff = {1'b0, w_r[NIB-1:0]} - {1'b0, operand[NIB-1:0]};
    swapped  = {mem_rdata[NIB-1:0], mem_rdata[7:NIB]};
  end

  // flags: borrow polarity is inverted, set means no borrow happened
  always_comb
  begin
    flags_nxt                 = FLAGS_RST;
    flags_nxt[FLG_BORROW]     = ~diff[8];
    flags_nxt[FLG_NIB_BORROW] = ~nib_diff[NIB];
    flags_nxt[FLG_ZERO]       = (diff[7:0] == BYTE_ZERO);
    flags_nxt[FLG_WRAP]       = (w_r[7] != operand[7]) && (diff[7] != w_r[7]);
  end

  // skip decision for the three test forms
  always_comb
  begin
    case (exec_op)
      OP_SKIP_Z:      skip_cond = (mem_rdata == BYTE_ZERO);
      OP_SKIP_Z_LOAD: skip_cond = (mem_rdata == BYTE_ZERO);
      OP_SKIP_BIT:    skip_cond = ~mem_rdata[exec_bit];
      default:        skip_cond = 1'b0;
    endcase
  end

  // ****************************************
  // issue sequencing and dummy slot
  // ****************************************
  // a taken skip holds off issue for exactly one cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      state_r <= ST_RUN;
    else
    begin
      case (state_r)
        ST_RUN:   state_r <= (accept && skip_cond) ? ST_DUMMY : ST_RUN;
        ST_DUMMY: state_r <= ST_RUN;
        default:  state_r <= ST_RUN;
      endcase
    end
  end

  // completion and skip pulses, one cycle after issue
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      exec_done  <= 1'b0;
      skip_taken <= 1'b0;
    end
    else
    begin
      exec_done  <= accept;
      skip_taken <= accept && skip_cond;
    end
  end

  // taken-skip counter, wraps silently
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      skips_r <= '0;
    else if (accept && skip_cond)
      skips_r <= skips_r + 1'b1;
  end

  // ****************************************
  // data memory write-back
  // ****************************************
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mem_we    <= 1'b0;
      mem_waddr <= '0;
      mem_wdata <= BYTE_ZERO;
    end
    else
    begin
      mem_we <= accept && ((exec_op == OP_SUB_MEM) || (exec_op == OP_SWAP));
      if (accept)
      begin
        mem_waddr <= exec_addr;
        mem_wdata <= (exec_op == OP_SUB_MEM) ? diff[7:0] : swapped;
      end
    end
  end

  // ****************************************
  // working register and flags
  // ****************************************
  // execution wins over a software write in the same cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      w_r <= WREG_RST;
    else if (accept && ((exec_op == OP_SUB) || (exec_op == OP_SUBI)))
      w_r <= diff[7:0];
    else if (accept && (exec_op == OP_SWAP_W))
      w_r <= swapped;
    else if (accept && (exec_op == OP_SKIP_Z_LOAD))
      w_r <= mem_rdata;
    else if (wr_wreg)
      w_r <= s_axi_wdata[7:0];
  end

  // only subtractions and software writes to the status register touch the flags
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      flags_r <= FLAGS_RST;
    else if (accept && is_sub)
      flags_r <= flags_nxt;
    else if (wr_status)
      flags_r <= s_axi_wdata[FLAG_W-1:0];
  end

  // ****************************************
  // axi4-lite slave
  // ****************************************
  // address and data taken together; simpler than buffering either alone
  assign s_axi_awready = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
  assign s_axi_wready  = s_axi_awready;
  assign wr_fire       = s_axi_awready;
  assign wr_wreg       = wr_fire && s_axi_wstrb[0] && (s_axi_awaddr == ADDR_WREG);
  assign wr_status     = wr_fire && s_axi_wstrb[0] && (s_axi_awaddr == ADDR_STATUS);
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire       = s_axi_arvalid && s_axi_arready;

  // write response; the skip counter is read-only
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      if ((s_axi_awaddr == ADDR_WREG) || (s_axi_awaddr == ADDR_STATUS))
        s_axi_bresp <= RESP_OKAY;
      else
        s_axi_bresp <= RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // read data, zero above the field widths
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end
    else if (rd_fire)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= RESP_OKAY;
      s_axi_rdata  <= '0;
      if (s_axi_araddr == ADDR_WREG)
        s_axi_rdata[7:0] <= w_r;
      else if (s_axi_araddr == ADDR_STATUS)
        s_axi_rdata[FLAG_W-1:0] <= flags_r;
      else if (s_axi_araddr == ADDR_SKIPS)
        s_axi_rdata[CNT_W-1:0] <= skips_r;
      else
        s_axi_rresp <= RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // ****************************************
  // assertions
  // ****************************************
  a_mem_sub_writeback: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(accept) && ($past(exec_op) == OP_SUB_MEM) |->
      mem_we && (mem_wdata == 8'($past(w_r) - $past(mem_rdata))) && (w_r == $past(w_r)))
    else $error("memory subtract result wrong");

  a_borrow_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(accept) && ($past(exec_op) == OP_SUBI) |->
      flags_r[FLG_BORROW] == ($past(w_r) >= $past(exec_imm)))
    else $error("borrow flag wrong");

  a_subi_result: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(accept) && ($past(exec_op) == OP_SUBI) |->
      (w_r == 8'($past(w_r) - $past(exec_imm))) && !mem_we)
    else $error("immediate subtract result wrong");

  a_swap_inplace: assert property (@(posedge aclk) disable iff (!aresetn)
    accept && (exec_op == OP_SWAP) |=>
      mem_we && (mem_wdata[3:0] == $past(mem_rdata[7:4])) && (mem_wdata[7:4] == $past(mem_rdata[3:0])))
    else $error("in-place swap wrong");

  a_swap_to_w: assert property (@(posedge aclk) disable iff (!aresetn)
    accept && (exec_op == OP_SWAP_W) |=>
      !mem_we && (w_r == {$past(mem_rdata[3:0]), $past(mem_rdata[7:4])}))
    else $error("swap into working register wrong");

  a_skip_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    accept && (exec_op == OP_SKIP_Z) |=> (skip_taken == ($past(mem_rdata) == BYTE_ZERO)))
    else $error("skip on zero wrong");

  a_dummy_cycle: assert property (@(posedge aclk) disable iff (!aresetn)
    skip_taken |-> dummy_slot && !exec_ready ##1 exec_ready && !dummy_slot)
    else $error("dummy cycle not exactly one");

  a_skip_load: assert property (@(posedge aclk) disable iff (!aresetn)
    accept && (exec_op == OP_SKIP_Z_LOAD) |=>
      (w_r == $past(mem_rdata)) && (skip_taken == (w_r == BYTE_ZERO)))
    else $error("skip with load wrong");

  a_bit_skip: assert property (@(posedge aclk) disable iff (!aresetn)
    accept && (exec_op == OP_SKIP_BIT) |=> (skip_taken != $past(mem_rdata[exec_bit])))
    else $error("bit test skip wrong");

  a_no_dummy: assert property (@(posedge aclk) disable iff (!aresetn)
    exec_done && !skip_taken |-> exec_ready && !dummy_slot)
    else $error("dummy cycle without skip");

  a_flags_kept: assert property (@(posedge aclk) disable iff (!aresetn)
    accept && !is_sub && !wr_status |=> $stable(flags_r))
    else $error("flags changed by non-subtract");

  a_zero_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(accept) && ($past(exec_op) == OP_SUB) |->
      flags_r[FLG_ZERO] == ($past(w_r) == $past(mem_rdata)))
    else $error("zero flag wrong");

endmodule

// ===== bench/data_mem_model.sv
// data memory model on the far side of the execution unit
`timescale 1ns/1ps
module data_mem_model (
  // clock
  input  wire logic       aclk,
  // access from the unit
  input  wire logic [7:0] rd_addr,
  input  wire logic       we,
  input  wire logic [7:0] waddr,
  input  wire logic [7:0] wdata,
  output logic      [7:0] rdata
);
  logic [7:0] mem [256];
  // write lands at the edge that closes the unit's pulse
  always @(posedge aclk)
  begin
    if (we)
      mem[waddr] <= wdata;
  end
  // forward a write still in flight, the unit itself does not
  assign rdata = (we && waddr == rd_addr) ? wdata : mem[rd_addr];
endmodule

// ===== bench/testbench.sv
// self-checking bench for the subtract, exchange and skip unit
`timescale 1ns/1ps
module testbench
  import subtract_swap_skip_pkg::*;
;
  logic        aclk = 1'b0, aresetn = 1'b0, ev = 1'b0, awv = 1'b0, wv = 1'b0, brdy = 1'b0, arv = 1'b0, rrdy = 1'b0;
  exec_op_e    op = OP_SUB;
  logic [7:0]  ea = 8'h00, imm = 8'h00, mrd, w_reg, mwd, mwa;
  logic [2:0]  eb = 3'h0;
  logic [3:0]  awa = 4'h0, ara = 4'h0, wstrb = 4'hf;
  logic [31:0] wd = 32'h0, rd;
  logic [1:0]  bresp, rresp;
  logic        erdy, done, skp, dmy, mwe, awr, wr, bv, arr, rv;
  logic [4:0]  cap;
  int          errors = 0, num_checks = 0, cycles = 0, skips = 0;

  // 100 MHz clock
  always #5 aclk = ~aclk;

  subtract_swap_skip_exec dut (.aclk(aclk), .aresetn(aresetn), .exec_valid(ev), .exec_ready(erdy), .exec_op(op),
    .exec_addr(ea), .exec_imm(imm), .exec_bit(eb), .mem_rdata(mrd), .exec_done(done), .skip_taken(skp),
    .dummy_slot(dmy), .mem_we(mwe), .mem_waddr(mwa), .mem_wdata(mwd), .working_register(w_reg),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(brdy),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rresp),
    .s_axi_rvalid(rv), .s_axi_rready(rrdy));
  data_mem_model mdl (.aclk(aclk), .rd_addr(ea), .we(mwe), .waddr(mwa), .wdata(mwd), .rdata(mrd));

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awa  <= a;
    wd   <= d;
    awv  <= 1'b1;
    wv   <= 1'b1;
    brdy <= 1'b1;
    do @(posedge aclk); while (!(awr && wr));
    awv <= 1'b0;
    wv  <= 1'b0;
    while (!bv) @(posedge aclk);
    check(32'(bresp), 32'(er));
    brdy <= 1'b0;
  endtask

  task automatic axi_rd(input logic [3:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge aclk);
    ara  <= a;
    arv  <= 1'b1;
    rrdy <= 1'b1;
    do @(posedge aclk); while (!arr);
    arv <= 1'b0;
    while (!rv) @(posedge aclk);
    check(32'(rresp), 32'(er));
    check(rd, exp);
    rrdy <= 1'b0;
  endtask

  task automatic mem_put(input logic [7:0] a, input logic [7:0] v);
    @(posedge aclk);
    mdl.mem[a] <= v;
  endtask

  // offer one instruction, hold it while refused, capture the answer cycle
  task automatic issue(input exec_op_e o, input logic [7:0] a, input logic [7:0] i, input logic [2:0] b);
    @(posedge aclk);
    op  <= o;
    ea  <= a;
    imm <= i;
    eb  <= b;
    ev  <= 1'b1;
    do @(posedge aclk); while (!erdy);
    ev <= 1'b0;
    @(negedge aclk);
    cap = {done, skp, dmy, erdy, mwe};
  endtask

  // flags as {wrap, zero, nibble borrow, borrow}, borrow bits high when none occurred
  function automatic logic [31:0] sub_flags(input logic [7:0] a, input logic [7:0] b);
    logic [7:0] r;
    r = a - b;
    return {28'h0, (a[7] != b[7]) && (r[7] != a[7]), r == 8'h00, a[3:0] >= b[3:0], a >= b};
  endfunction

  // ****************************************
  // scenarios
  // ****************************************
  task automatic test_sub();
    logic [7:0] a [4] = '{8'h05, 8'h03, 8'h80, 8'h5a};
    logic [7:0] b [4] = '{8'h13, 8'h05, 8'h01, 8'h5a};
    logic [7:0] r;
    // ops 0..2: into w, into memory, immediate
    for (int k = 0; k < 12; k++)
    begin
      r = a[k%4] - b[k%4];
      axi_wr(ADDR_WREG, {24'h0, a[k%4]}, RESP_OKAY);
      mem_put(8'h10, (k / 4 == 2) ? ~b[k%4] : b[k%4]);
      issue(exec_op_e'(k / 4), 8'h10, b[k%4], 3'h0);
      check(32'(cap[0]), 32'(k / 4 == 1));
      axi_rd(ADDR_STATUS, sub_flags(a[k%4], b[k%4]), RESP_OKAY);
      check(32'(w_reg), 32'((k / 4 == 1) ? a[k%4] : r));
      if (k / 4 == 1)
        check(32'(mdl.mem[8'h10]), 32'(r));
    end
    $display("test sub done");
  endtask

  task automatic test_swap();
    axi_wr(ADDR_STATUS, 32'ha, RESP_OKAY);
    axi_wr(ADDR_WREG, 32'h77, RESP_OKAY);
    mem_put(8'h20, 8'h3c);
    issue(OP_SWAP, 8'h20, 8'h00, 3'h0);
    check(32'({cap[0], mwd}), 32'h1c3);
    check(32'(mwa), 32'h20);
    check(32'(w_reg), 32'h77);
    issue(exec_op_e'(4), 8'h20, 8'h00, 3'h0);
    check(32'(cap[0]), 32'h0);
    check(32'(w_reg), 32'h3c);
    check(32'(mdl.mem[8'h20]), 32'hc3);
    axi_rd(ADDR_STATUS, 32'ha, RESP_OKAY);
    $display("test swap done");
  endtask

  task automatic skip_one(input exec_op_e o, input logic [7:0] v, input logic [2:0] b, input logic exp);
    mem_put(8'h30, v);
    issue(o, 8'h30, 8'h00, b);
    skips += int'(exp);
    check(32'(cap), 32'({1'b1, exp, exp, !exp, 1'b0}));
    if (o == exec_op_e'(6))
      check(32'(w_reg), 32'(v));
  endtask

  task automatic test_skip();
    axi_wr(ADDR_STATUS, 32'h5, RESP_OKAY);
    // ops 5..7: byte zero, byte zero with load, bit zero
    skip_one(exec_op_e'(5), 8'h00, 3'h0, 1'b1);
    skip_one(exec_op_e'(5), 8'h01, 3'h0, 1'b0);
    skip_one(exec_op_e'(6), 8'h00, 3'h0, 1'b1);
    skip_one(exec_op_e'(6), 8'h80, 3'h0, 1'b0);
    for (int i = 0; i < 8; i++)
    begin
      skip_one(exec_op_e'(7), ~(8'h01 << i), 3'(i), 1'b1);
      skip_one(exec_op_e'(7), 8'h01 << i, 3'(i), 1'b0);
    end
    axi_rd(ADDR_STATUS, 32'h5, RESP_OKAY);
    axi_rd(ADDR_SKIPS, 32'(skips), RESP_OKAY);
    axi_wr(ADDR_SKIPS, 32'h0, RESP_SLVERR);
    axi_rd(4'hc, 32'h0, RESP_SLVERR);
    $display("test skip done");
  endtask

  // ****************************************
  // main sequence and hang guard
  // ****************************************
  initial
  begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(ADDR_WREG, 32'h0, RESP_OKAY);
    axi_rd(ADDR_STATUS, 32'h0, RESP_OKAY);
    axi_rd(ADDR_SKIPS, 32'h0, RESP_OKAY);
    $display("test reset done");
    test_sub();
    test_swap();
    test_skip();
    report_and_stop();
  end

  // whole run needs well under a thousand cycles
  always @(posedge aclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      errors++;
      report_and_stop();
    end
  end
endmodule
